/* File: rtl/jtp_pkg.sv */
package jtp_pkg;
	// ------------------------------------------------------------
	// tap controller states
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		TLR, RTI,
		SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} jtp_state_t;

	// ------------------------------------------------------------
	// test data register selection
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		DR_BYPASS, DR_IDENT, DR_BSCAN, DR_PROBE
	} jtp_dr_sel_t;

	// ------------------------------------------------------------
	// instruction register
	// ------------------------------------------------------------
	localparam int unsigned IR_W        = 5;
	localparam logic [4:0]  OP_EXTEST   = 5'h00;
	localparam logic [4:0]  OP_SAMPLE   = 5'h01;
	localparam logic [4:0]  OP_INTEST   = 5'h02;
	localparam logic [4:0]  OP_USERCODE = 5'h03;
	localparam logic [4:0]  OP_IDCODE   = 5'h04;
	localparam logic [4:0]  OP_HIGHZ    = 5'h0e;
	localparam logic [4:0]  OP_CLAMP    = 5'h0f;
	localparam logic [4:0]  OP_PROBE    = 5'h10;
	localparam logic [4:0]  OP_BYPASS   = 5'h1f;
	localparam logic [4:0]  IR_CAPTURE  = 5'h1d;
	localparam logic [4:0]  IR_RESET    = OP_IDCODE;

	// ------------------------------------------------------------
	// identification word layout
	// ------------------------------------------------------------
	localparam int unsigned ID_W        = 32;
	localparam int unsigned ID_MARK_POS = 0;
	localparam int unsigned ID_MFR_LSB  = 1;
	localparam int unsigned ID_MFR_W    = 11;
	localparam int unsigned ID_PART_LSB = 12;
	localparam int unsigned ID_PART_W   = 16;
	localparam int unsigned ID_REV_LSB  = 28;
	localparam int unsigned ID_REV_W    = 4;
	localparam logic        ID_MARK     = 1'b1;

	// ------------------------------------------------------------
	// timing and crossing
	// ------------------------------------------------------------
	localparam int unsigned TMS_RESET_TCKS = 5;
	localparam int unsigned SYNC_BITS      = 3;
endpackage : jtp_pkg

/* File: rtl/jtp_tap.sv */
`timescale 1ns/100ps
// Contract
// RULE1: flexible mode, tms low routes pins to test
// RULE2: first tck edge leaves reset for idle
// RULE3: five tms-high clocks release shared pins
// RULE4: sixteen states, advancing on rising tck by tms
// RULE5: ir states run ir, dr states run selected register
// RULE6: power-up or trst enters test-logic-reset
// RULE7: five tms-high clocks reach reset from anywhere
// RULE8: five ir cells, shift plus latch stage
// RULE9: capture_ir loads 11101
// RULE10: shift_ir shifts toward tdo, latch holds
// RULE11: update_ir latches on falling tck
// RULE12: reset latches idcode, shift stage kept
// RULE13: decode extest, sample, bypass opcodes
// RULE14: bypass is exactly one bit
// RULE15: decode intest, usercode, idcode opcodes
// RULE16: highz opcode floats all user pins
// RULE17: clamp opcode drives pins from boundary register
// RULE18: probe opcode selects internal probe
// RULE19: unassigned opcodes reserved; tester avoids them
// RULE20: intest clock pins observe only
// RULE21: 32-bit identification register for idcode/usercode
// RULE22: id word: mark, maker, part, revision
// RULE23: tdo floats unless scanning
// RULE24: trst active low, asynchronous, overrides all
// RULE25: sample on rising tck, tdo on falling
// RULE26: bypass captures zero in capture_dr
// RULE27: transitions follow standard state graph
module jtp_tap #(
	parameter logic [10:0] ID_MFR  = 11'h055, // arbitrary value
	parameter logic [15:0] ID_PART = 16'h0a5a, // arbitrary value
	parameter logic [3:0]  ID_REV  = 4'h1     // arbitrary value
) (
	input  wire logic        sys_clk_in,
	input  wire logic        reset_in,
	input  wire logic        tck_in,
	input  wire logic        tms_in,
	input  wire logic        tdi_in,
	input  wire logic        trst_n_in,
	input  wire logic        flex_mode_in,
	input  wire logic [31:0] user_code_in,
	input  wire logic        bscan_so_in,
	input  wire logic        probe_so_in,
	output logic             tdo_out,
	output logic             tdo_oe_n_out,
	output logic             pins_route_out,
	output logic             dr_capture_out,
	output logic             dr_shift_out,
	output logic             dr_update_out,
	output logic             bscan_sel_out,
	output logic             probe_sel_out,
	output logic             io_highz_out,
	output logic             io_from_bscan_out,
	output logic             intest_out,
	output logic             clk_cells_observe_out,
	output logic             sys_pins_route_out,
	output logic             sys_io_highz_out,
	output logic             sys_io_from_bscan_out
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic jtp_pkg::jtp_state_t next_state(jtp_pkg::jtp_state_t s, logic tms);
		case (s)
			jtp_pkg::TLR:    next_state = tms ? jtp_pkg::TLR    : jtp_pkg::RTI;
			jtp_pkg::RTI:    next_state = tms ? jtp_pkg::SEL_DR : jtp_pkg::RTI;
			jtp_pkg::SEL_DR: next_state = tms ? jtp_pkg::SEL_IR : jtp_pkg::CAP_DR;
			jtp_pkg::CAP_DR: next_state = tms ? jtp_pkg::EX1_DR : jtp_pkg::SHF_DR;
			jtp_pkg::SHF_DR: next_state = tms ? jtp_pkg::EX1_DR : jtp_pkg::SHF_DR;
			jtp_pkg::EX1_DR: next_state = tms ? jtp_pkg::UPD_DR : jtp_pkg::PAU_DR;
			jtp_pkg::PAU_DR: next_state = tms ? jtp_pkg::EX2_DR : jtp_pkg::PAU_DR;
			jtp_pkg::EX2_DR: next_state = tms ? jtp_pkg::UPD_DR : jtp_pkg::SHF_DR;
			jtp_pkg::UPD_DR: next_state = tms ? jtp_pkg::SEL_DR : jtp_pkg::RTI;
			jtp_pkg::SEL_IR: next_state = tms ? jtp_pkg::TLR    : jtp_pkg::CAP_IR;
			jtp_pkg::CAP_IR: next_state = tms ? jtp_pkg::EX1_IR : jtp_pkg::SHF_IR;
			jtp_pkg::SHF_IR: next_state = tms ? jtp_pkg::EX1_IR : jtp_pkg::SHF_IR;
			jtp_pkg::EX1_IR: next_state = tms ? jtp_pkg::UPD_IR : jtp_pkg::PAU_IR;
			jtp_pkg::PAU_IR: next_state = tms ? jtp_pkg::EX2_IR : jtp_pkg::PAU_IR;
			jtp_pkg::EX2_IR: next_state = tms ? jtp_pkg::UPD_IR : jtp_pkg::SHF_IR;
			jtp_pkg::UPD_IR: next_state = tms ? jtp_pkg::SEL_DR : jtp_pkg::RTI;
			default:         next_state = jtp_pkg::TLR;
		endcase
	endfunction : next_state

	function automatic jtp_pkg::jtp_dr_sel_t dr_select(logic [4:0] op);
		case (op)
			jtp_pkg::OP_EXTEST,
			jtp_pkg::OP_SAMPLE,
			jtp_pkg::OP_INTEST:   dr_select = jtp_pkg::DR_BSCAN;
			jtp_pkg::OP_USERCODE,
			jtp_pkg::OP_IDCODE:   dr_select = jtp_pkg::DR_IDENT;
			jtp_pkg::OP_PROBE:    dr_select = jtp_pkg::DR_PROBE;
			// reserved codes fall to the one-bit path so a stray load is harmless
			default:              dr_select = jtp_pkg::DR_BYPASS;
		endcase
	endfunction : dr_select

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	// the scan paths are built for five instruction and thirty-two id cells
	localparam int unsigned ID_SUM = jtp_pkg::ID_MFR_W + jtp_pkg::ID_PART_W + jtp_pkg::ID_REV_W + 1;
	if (jtp_pkg::IR_W != 5 || jtp_pkg::ID_W != 32 || ID_SUM != jtp_pkg::ID_W) begin : g_bad_size
		$error("identification or instruction width does not match the scan paths");
	end

	// ------------------------------------------------------------
	// tck domain reset
	// ------------------------------------------------------------
	// power-up reset also clears the tap even though tck may be stopped
	logic tap_rst;
	assign tap_rst = ~trst_n_in | reset_in; // RULE6 RULE24

	// ------------------------------------------------------------
	// tap controller
	// ------------------------------------------------------------
	jtp_pkg::jtp_state_t state_q;
	jtp_pkg::jtp_state_t state_d;

	assign state_d = next_state(state_q, tms_in); // RULE27

	always_ff @(posedge tck_in or posedge tap_rst) begin
		if (tap_rst) begin
			state_q <= jtp_pkg::TLR; // RULE6 RULE24
		end else begin
			state_q <= state_d; // RULE4 RULE2 RULE7 RULE25
		end
	end

	// ------------------------------------------------------------
	// instruction register
	// ------------------------------------------------------------
	logic [4:0] ir_sh_q;
	logic [4:0] ir_q;

	// power-up gives the shift stage a known value; trst and the tms reset leave it alone
	always_ff @(posedge tck_in or posedge reset_in) begin
		if (reset_in) begin
			ir_sh_q <= jtp_pkg::IR_CAPTURE;
		end else begin
			case (state_q)
				jtp_pkg::CAP_IR: ir_sh_q <= jtp_pkg::IR_CAPTURE; // RULE9
				jtp_pkg::SHF_IR: ir_sh_q <= {tdi_in, ir_sh_q[4:1]}; // RULE10 RULE8
				default:         ir_sh_q <= ir_sh_q; // RULE12
			endcase
		end
	end

	always_ff @(negedge tck_in or posedge tap_rst) begin
		if (tap_rst) begin
			ir_q <= jtp_pkg::IR_RESET; // RULE12
		end else if (state_q == jtp_pkg::TLR) begin
			ir_q <= jtp_pkg::IR_RESET; // RULE12
		end else if (state_q == jtp_pkg::UPD_IR) begin
			ir_q <= ir_sh_q; // RULE11 RULE8
		end
	end

	// ------------------------------------------------------------
	// instruction decode
	// ------------------------------------------------------------
	jtp_pkg::jtp_dr_sel_t dr_sel;
	assign dr_sel = dr_select(ir_q); // RULE5 RULE13 RULE15 RULE19

	assign bscan_sel_out     = (dr_sel == jtp_pkg::DR_BSCAN); // RULE13 RULE15
	assign probe_sel_out     = (dr_sel == jtp_pkg::DR_PROBE); // RULE18
	assign io_highz_out      = (ir_q == jtp_pkg::OP_HIGHZ); // RULE16
	assign io_from_bscan_out = (ir_q == jtp_pkg::OP_CLAMP) |
	                           (ir_q == jtp_pkg::OP_EXTEST); // RULE17
	assign intest_out        = (ir_q == jtp_pkg::OP_INTEST);
	// high-speed clock cells never drive; they only capture, even in intest
	assign clk_cells_observe_out = 1'b1; // RULE20

	assign dr_capture_out = (state_q == jtp_pkg::CAP_DR); // RULE5
	assign dr_shift_out   = (state_q == jtp_pkg::SHF_DR); // RULE5
	assign dr_update_out  = (state_q == jtp_pkg::UPD_DR); // RULE5

	// ------------------------------------------------------------
	// bypass and identification registers
	// ------------------------------------------------------------
	logic        byp_q;
	logic [31:0] id_sh_q;
	logic [31:0] id_word;

	always_comb begin
		id_word = '0;
		id_word[jtp_pkg::ID_MARK_POS] = jtp_pkg::ID_MARK; // RULE22
		id_word[jtp_pkg::ID_MFR_LSB +: jtp_pkg::ID_MFR_W]   = ID_MFR; // RULE22
		id_word[jtp_pkg::ID_PART_LSB +: jtp_pkg::ID_PART_W] = ID_PART; // RULE22
		id_word[jtp_pkg::ID_REV_LSB +: jtp_pkg::ID_REV_W]   = ID_REV; // RULE22
	end

	always_ff @(posedge tck_in) begin
		if (dr_sel == jtp_pkg::DR_BYPASS) begin
			if (state_q == jtp_pkg::CAP_DR) begin
				byp_q <= 1'b0; // RULE26
			end else if (state_q == jtp_pkg::SHF_DR) begin
				byp_q <= tdi_in; // RULE14
			end
		end
	end

	always_ff @(posedge tck_in) begin
		if (dr_sel == jtp_pkg::DR_IDENT) begin
			if (state_q == jtp_pkg::CAP_DR) begin
				id_sh_q <= (ir_q == jtp_pkg::OP_USERCODE) ? user_code_in : id_word; // RULE21
			end else if (state_q == jtp_pkg::SHF_DR) begin
				id_sh_q <= {tdi_in, id_sh_q[31:1]}; // RULE21
			end
		end
	end

	// ------------------------------------------------------------
	// serial output, updated on the falling edge
	// ------------------------------------------------------------
	logic tdo_q;
	logic tdo_oe_n_q;
	logic scan_bit;

	always_comb begin
		scan_bit = 1'b0;
		if (state_q == jtp_pkg::SHF_IR) begin
			scan_bit = ir_sh_q[0];
		end else begin
			case (dr_sel)
				jtp_pkg::DR_BYPASS: scan_bit = byp_q; // RULE14
				jtp_pkg::DR_IDENT:  scan_bit = id_sh_q[0];
				jtp_pkg::DR_BSCAN:  scan_bit = bscan_so_in;
				jtp_pkg::DR_PROBE:  scan_bit = probe_so_in;
				default:            scan_bit = 1'b0;
			endcase
		end
	end

	always_ff @(negedge tck_in or posedge tap_rst) begin
		if (tap_rst) begin
			tdo_q      <= 1'b0;
			tdo_oe_n_q <= 1'b1;
		end else begin
			tdo_q      <= scan_bit; // RULE25
			tdo_oe_n_q <= ~((state_q == jtp_pkg::SHF_IR) |
			               (state_q == jtp_pkg::SHF_DR)); // RULE23
		end
	end

	assign tdo_out      = tdo_q;
	assign tdo_oe_n_out = tdo_oe_n_q;

	// ------------------------------------------------------------
	// shared pin ownership
	// ------------------------------------------------------------
	// in flexible mode a low tms claims the pins before the first tck edge
	assign pins_route_out = ~flex_mode_in | (state_q != jtp_pkg::TLR) | ~tms_in; // RULE1 RULE3

	// ------------------------------------------------------------
	// crossing into the system clock domain
	// ------------------------------------------------------------
	// quasi-static levels: each bit synchronised alone, counted once stages agree
	localparam int unsigned XW = 3;
	logic [XW-1:0] x_src;
	logic [XW-1:0] x_s1_q;
	logic [XW-1:0] x_s2_q;
	logic [XW-1:0] x_s3_q;
	logic [XW-1:0] x_out_q;

	assign x_src = {io_from_bscan_out, io_highz_out, pins_route_out};

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			x_s1_q <= '0;
			x_s2_q <= '0;
			x_s3_q <= '0;
		end else begin
			x_s1_q <= x_src;
			x_s2_q <= x_s1_q;
			x_s3_q <= x_s2_q;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			x_out_q <= '0;
		end else begin
			for (int i = 0; i < XW; i++) begin
				if (x_s2_q[i] == x_s3_q[i]) begin
					x_out_q[i] <= x_s2_q[i];
				end
			end
		end
	end

	assign sys_pins_route_out    = x_out_q[0]; // RULE3
	assign sys_io_highz_out      = x_out_q[1];
	assign sys_io_from_bscan_out = x_out_q[2];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence ir_capture_s;
		state_q == jtp_pkg::CAP_IR ##1 state_q == jtp_pkg::SHF_IR;
	endsequence

	sequence tms_held_s;
		tms_in [*5];
	endsequence

	tms_reset_a: assert property (@(posedge tck_in) disable iff (tap_rst) // RULE7
		tms_held_s |=> state_q == jtp_pkg::TLR)
		else $error("five tms-high clocks did not reach reset");

	flex_release_a: assert property (@(posedge tck_in) disable iff (tap_rst) // RULE3
		(flex_mode_in && tms_in) throughout (tms_held_s ##1 tms_in) |-> !pins_route_out)
		else $error("shared pins not released after five tms-high clocks");

	idle_entry_a: assert property (@(posedge tck_in) disable iff (tap_rst) // RULE2
		(state_q == jtp_pkg::TLR && !tms_in) |=> state_q == jtp_pkg::RTI)
		else $error("tms low in reset did not enter idle");

	ir_capture_a: assert property (@(posedge tck_in) disable iff (tap_rst) // RULE9
		ir_capture_s |-> ir_sh_q == jtp_pkg::IR_CAPTURE)
		else $error("capture pattern not loaded into ir shift stage");

	ir_shift_a: assert property (@(posedge tck_in) disable iff (tap_rst) // RULE10
		state_q == jtp_pkg::SHF_IR |=>
		ir_sh_q == {$past(tdi_in), $past(ir_sh_q[4:1])} && $stable(ir_q))
		else $error("ir shift stage did not shift or latch moved");

	ir_update_a: assert property (@(posedge tck_in) disable iff (tap_rst) // RULE11
		state_q == jtp_pkg::UPD_IR |=> ir_q == $past(ir_sh_q))
		else $error("update did not latch the ir shift stage");

	ir_reset_a: assert property (@(posedge tck_in) disable iff (tap_rst) // RULE12
		state_q == jtp_pkg::TLR |=> ir_q == jtp_pkg::IR_RESET && $stable(ir_sh_q))
		else $error("reset did not select identification");

	bypass_cap_a: assert property (@(posedge tck_in) disable iff (tap_rst) // RULE26
		(state_q == jtp_pkg::CAP_DR && ir_q == jtp_pkg::OP_BYPASS) |=> byp_q == 1'b0)
		else $error("bypass bit did not capture zero");

	bypass_shift_a: assert property (@(posedge tck_in) disable iff (tap_rst) // RULE14
		(state_q == jtp_pkg::SHF_DR && dr_sel == jtp_pkg::DR_BYPASS) |=> byp_q == $past(tdi_in))
		else $error("bypass bit did not take the serial input");

	id_capture_a: assert property (@(posedge tck_in) disable iff (tap_rst) // RULE22
		(state_q == jtp_pkg::CAP_DR && ir_q == jtp_pkg::OP_IDCODE) |=>
		id_sh_q[0] == 1'b1 && id_sh_q[11:1] == ID_MFR &&
		id_sh_q[27:12] == ID_PART && id_sh_q[31:28] == ID_REV)
		else $error("identification word captured wrongly");

	sequence id_shift_s;
		state_q == jtp_pkg::SHF_DR && dr_sel == jtp_pkg::DR_IDENT;
	endsequence

	id_shift_a: assert property (@(posedge tck_in) disable iff (tap_rst) // RULE21
		id_shift_s |=> id_sh_q == {$past(tdi_in), $past(id_sh_q[31:1])})
		else $error("identification register did not shift toward tdo");

	// the enable is set on the falling edge from the state that the rising edge entered
	tdo_float_a: assert property (@(posedge tck_in) disable iff (tap_rst) // RULE23
		!(state_q inside {jtp_pkg::SHF_IR, jtp_pkg::SHF_DR}) |-> tdo_oe_n_q)
		else $error("tdo driven outside a scan");

	tdo_drive_a: assert property (@(posedge tck_in) disable iff (tap_rst) // RULE23
		state_q inside {jtp_pkg::SHF_IR, jtp_pkg::SHF_DR} |-> !tdo_oe_n_q)
		else $error("tdo not driven during a scan");

	tdo_ir_a: assert property (@(posedge tck_in) disable iff (tap_rst) // RULE25
		state_q == jtp_pkg::SHF_IR |-> tdo_q == ir_sh_q[0])
		else $error("tdo does not show the ir shift stage");

	flex_claim_a: assert property (@(posedge tck_in) disable iff (tap_rst) // RULE1
		(flex_mode_in && !tms_in) |-> pins_route_out)
		else $error("tms low did not claim the shared pins");
endmodule : jtp_tap

/* File: sim/jtp_tester.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// scan tester: tck stands low between its operations
// ------------------------------------------------------------
module jtp_tester (
	output logic      tck_out,
	output logic      tms_out,
	output logic      tdi_out,
	output logic      trst_n_out,
	input  wire logic tdo_in,
	input  wire logic tdo_oe_n_in
);
	logic last_q;
	logic tdo_w;
	// a released tdo shows the inverse of its last level, so a float never passes
	assign tdo_w = tdo_oe_n_in ? ~last_q : tdo_in;
	initial begin
		tck_out    = 1'b0;
		tms_out    = 1'b1;
		tdi_out    = 1'b1;
		trst_n_out = 1'b1;
		last_q     = 1'b0;
	end
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		tms_out = tms;
		tdi_out = tdi;
		#80;
		tdo = tdo_w;
		last_q = tdo_w;
		tck_out = 1'b1;
		#80;
		tck_out = 1'b0;
	endtask : step
	task automatic scan(input int n, input logic [31:0] din, output logic [31:0] dout);
		logic bit_v;
		dout = 32'h0000_0000;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], bit_v);
			dout[i] = bit_v;
		end
	endtask : scan
	task automatic go_reset();
		logic bit_v;
		repeat (5) step(1'b1, 1'b1, bit_v);
	endtask : go_reset
	task automatic set_trst(input logic level);
		trst_n_out = level;
	endtask : set_trst
endmodule : jtp_tester

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
	localparam logic [10:0] ID_MFR_V  = 11'h3c5;  // arbitrary value
	localparam logic [15:0] ID_PART_V = 16'h5e21; // arbitrary value
	localparam logic [3:0]  ID_REV_V  = 4'h6;     // arbitrary value
	localparam logic [31:0] ID_WORD   = {ID_REV_V, ID_PART_V, ID_MFR_V, 1'b1};
	// only assigned opcodes are loaded; the rest are kept for factory use
	localparam logic [4:0]  OPS [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04,
	                                   5'h0e, 5'h0f, 5'h10, 5'h1f};
	logic        sys_clk_in, reset_in, flex_mode_in, bscan_so_in, probe_so_in;
	logic [31:0] user_code_in;
	logic        tck, tms, tdi, trst_n, tdo_out, tdo_oe_n_out, pins_route_out;
	logic        dr_shift_out, bscan_sel_out, probe_sel_out, io_highz_out;
	logic        io_from_bscan_out, intest_out, sys_io_highz_out, b;
	logic        sys_pins_route_out, sys_io_from_bscan_out, dr_capture_out, dr_update_out;
	logic        clk_obs, walk_tms;
	logic [2:0]  sys_v;
	logic [31:0] got;
	logic [31:0] din;
	logic [4:0]  op;
	logic [4:0]  seen;
	int          mismatches;
	int          checks;

	jtp_tester u_tst (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .trst_n_out(trst_n),
		.tdo_in(tdo_out), .tdo_oe_n_in(tdo_oe_n_out));
	jtp_tap #(.ID_MFR(ID_MFR_V), .ID_PART(ID_PART_V), .ID_REV(ID_REV_V)) u_dut (
		.sys_clk_in(sys_clk_in), .reset_in(reset_in), .tck_in(tck), .tms_in(tms),
		.tdi_in(tdi), .trst_n_in(trst_n), .flex_mode_in(flex_mode_in),
		.user_code_in(user_code_in), .bscan_so_in(bscan_so_in), .probe_so_in(probe_so_in),
		.tdo_out(tdo_out), .tdo_oe_n_out(tdo_oe_n_out), .pins_route_out(pins_route_out),
		.dr_capture_out(dr_capture_out), .dr_shift_out(dr_shift_out),
		.dr_update_out(dr_update_out),
		.bscan_sel_out(bscan_sel_out), .probe_sel_out(probe_sel_out),
		.io_highz_out(io_highz_out), .io_from_bscan_out(io_from_bscan_out),
		.intest_out(intest_out), .clk_cells_observe_out(clk_obs),
		.sys_pins_route_out(sys_pins_route_out), .sys_io_highz_out(sys_io_highz_out),
		.sys_io_from_bscan_out(sys_io_from_bscan_out));
	assign sys_v = {sys_io_from_bscan_out, sys_io_highz_out, sys_pins_route_out};

	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	// ------------------------------------------------------------
	// checking helpers
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen_v);
		checks++;
		if (exp !== seen_v) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen_v);
		end
	endtask : chk
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : final_report
	function automatic logic [4:0] dec(input logic [4:0] code);
		dec[4] = (code == 5'h00) || (code == 5'h01) || (code == 5'h02);
		dec[3] = (code == 5'h10);
		dec[2] = (code == 5'h0e);
		dec[1] = (code == 5'h0f) || (code == 5'h00);
		dec[0] = (code == 5'h02);
	endfunction : dec
	task automatic ir_load(input logic [4:0] code);
		logic [31:0] cap;
		u_tst.step(1'b1, 1'b0, b);
		u_tst.step(1'b1, 1'b0, b);
		u_tst.step(1'b0, 1'b0, b);
		u_tst.step(1'b0, 1'b0, b);
		u_tst.scan(5, {27'h000_0000, code}, cap);
		chk("ir capture", 32'h0000_001d, cap);
		u_tst.step(1'b1, 1'b0, b);
		u_tst.step(1'b0, 1'b0, b);
	endtask : ir_load
	task automatic dr(input int n, input logic [31:0] d, output logic [31:0] q);
		u_tst.step(1'b1, 1'b0, b);
		u_tst.step(1'b0, 1'b0, b);
		chk("dr capture", 32'h0000_0001, {31'h0000_0000, dr_capture_out});
		u_tst.step(1'b0, 1'b0, b);
		chk("dr shift", 32'h0000_0001, {31'h0000_0000, dr_shift_out});
		u_tst.scan(n, d, q);
		u_tst.step(1'b1, 1'b0, b);
		chk("dr update", 32'h0000_0001, {31'h0000_0000, dr_update_out});
		u_tst.step(1'b0, 1'b0, b);
		// the enable moves on the falling edge just made: let it settle first
		#1;
		chk("tdo idle", 32'h0000_0001, {31'h0000_0000, tdo_oe_n_out});
	endtask : dr
	task automatic sys_follow(input logic [2:0] exp);
		int i;
		for (i = 0; i < 8 && sys_v !== exp; i++) @(negedge sys_clk_in);
		chk("sys crossing", {29'h0000_0000, exp}, {29'h0000_0000, sys_v});
		if (i == 8) final_report();
	endtask : sys_follow
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		mismatches = 0;
		checks = 0;
		reset_in = 1'b1;
		flex_mode_in = 1'b1;
		user_code_in = 32'h0000_0000;
		bscan_so_in = 1'b0;
		probe_so_in = 1'b0;
		got = $urandom(32'h5c13_fa29);
		@(negedge sys_clk_in);
		user_code_in = $urandom;
		bscan_so_in = 1'($urandom);
		probe_so_in = 1'($urandom);
		repeat (20) @(negedge sys_clk_in);
		chk("reset oe", 32'h0000_0001, {31'h0000_0000, tdo_oe_n_out});
		reset_in = 1'b0;
		chk("pins held", 32'h0000_0000, {31'h0000_0000, pins_route_out});
		u_tst.step(1'b0, 1'b0, b);
		chk("pins routed", 32'h0000_0001, {31'h0000_0000, pins_route_out});
		chk("clock cells", 32'h0000_0001, {31'h0000_0000, clk_obs});
		for (int r = 0; r < 3; r++) begin
			for (int k = 0; k < 9; k++) begin
				op = OPS[(k + r * 4) % 9];
				ir_load(op);
				seen = {bscan_sel_out, probe_sel_out, io_highz_out, io_from_bscan_out, intest_out};
				chk("decode", {27'h000_0000, dec(op)}, {27'h000_0000, seen});
				sys_follow({op == 5'h00 || op == 5'h0f, op == 5'h0e, 1'b1});
				din = $urandom;
				if (op == 5'h03) begin
					dr(32, din, got);
					chk("usercode", user_code_in, got);
				end else if (op == 5'h1f || op == 5'h0e || op == 5'h0f) begin
					dr(8, din, got);
					chk("bypass", {24'h00_0000, din[6:0], 1'b0}, got);
				end else if (op == 5'h04) begin
					dr(32, din, got);
					chk("idcode op", ID_WORD, got);
				end else begin
					// the outside chains hold their serial out still, so every bit matches it
					dr(8, din, got);
					b = (op == 5'h10) ? probe_so_in : bscan_so_in;
					chk("chain path", {24'h00_0000, {8{b}}}, got);
				end
			end
			// never two tms highs in a row: the walk stays in the data column
			// and so never latches a reserved opcode
			walk_tms = 1'b0;
			repeat (12) begin
				walk_tms = 1'($urandom) & ~walk_tms;
				u_tst.step(walk_tms, 1'($urandom), b);
			end
			u_tst.go_reset();
			chk("pins released", 32'h0000_0000, {31'h0000_0000, pins_route_out});
			sys_follow(3'h0);
			u_tst.step(1'b0, 1'b0, b);
			dr(32, $urandom, got);
			chk("idcode", ID_WORD, got);
		end
		ir_load(5'h1f);
		u_tst.step(1'b1, 1'b0, b);
		u_tst.step(1'b0, 1'b0, b);
		u_tst.step(1'b0, 1'b0, b);
		#1;
		chk("shift oe", 32'h0000_0000, {31'h0000_0000, tdo_oe_n_out});
		#19;
		u_tst.set_trst(1'b0);
		#5;
		chk("trst oe", 32'h0000_0001, {31'h0000_0000, tdo_oe_n_out});
		u_tst.set_trst(1'b1);
		u_tst.step(1'b0, 1'b0, b);
		dr(32, $urandom, got);
		chk("idcode after trst", ID_WORD, got);
		final_report();
	end
	initial begin
		#900000;
		mismatches++;
		final_report();
	end
endmodule : tb_top
